// ==== common/mas_pkg.sv ====
`default_nettype none
package mas_pkg;

	// ------------------------------------------------------------
	// value format
	// ------------------------------------------------------------
	// analog values are signed milli-units: 1.000 is 1000
	localparam int VAL_W = 32;
	localparam int WIDE_W = 64;
	localparam int FRAC_BITS = 16;
	localparam int STATE_W = VAL_W + FRAC_BITS;
	localparam logic signed [VAL_W-1:0] RESULT_RESET = 32'sh0000_0000;
	localparam logic signed [STATE_W-1:0] FILT_STATE_RESET = 48'sh0000_0000_0000;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int FILT_STEP_US = 1000;
	localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * FILT_STEP_US;
	localparam int MS_PER_TENTH = 100;
	localparam int FILT_TIME_W = 10;
	localparam logic [FILT_TIME_W-1:0] FILT_MAX_TENTHS = 10'h258;
	localparam logic [FILT_TIME_W-1:0] FILT_TIME_OFF = 10'h000;

	// ------------------------------------------------------------
	// modes and unit tags
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FUNC_AVERAGE,
		FUNC_SWITCH_OVER,
		FUNC_PROCESS_SCALE,
		FUNC_DEVIATION_SCALE
	} mas_func_t;

	typedef enum logic [2:0] {
		UNITS_SOURCE,
		UNITS_NONE,
		UNITS_ABS_TEMP,
		UNITS_REL_TEMP,
		UNITS_POWER,
		UNITS_PROCESS,
		UNITS_REL_HUMIDITY
	} mas_units_t;

	localparam int NUM_IN = 4;

endpackage
`default_nettype wire

// ==== rtl/mas_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module mas_div (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic signed [mas_pkg::WIDE_W-1:0] dividend,
	input wire logic signed [mas_pkg::WIDE_W-1:0] divisor,
	output logic done,
	output logic signed [mas_pkg::WIDE_W-1:0] quotient
);
	import mas_pkg::*;

	// ------------------------------------------------------------
	// restoring divider, one bit per cycle, truncates toward zero
	// ------------------------------------------------------------
	logic [WIDE_W-1:0] quo_reg;
	logic [WIDE_W-1:0] dvs_reg;
	logic [WIDE_W-1:0] rem_reg;
	logic [6:0] cnt_reg;
	logic busy_reg;
	logic neg_reg;
	logic [WIDE_W:0] trial;
	logic [WIDE_W-1:0] rem_sh;

	always_comb begin
		rem_sh = {rem_reg[WIDE_W-2:0], quo_reg[WIDE_W-1]};
		trial = {1'b0, rem_sh} - {1'b0, dvs_reg};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			quo_reg <= 64'h0;
			dvs_reg <= 64'h0;
			rem_reg <= 64'h0;
			cnt_reg <= 7'h00;
			busy_reg <= 1'b0;
			neg_reg <= 1'b0;
			done <= 1'b0;
			quotient <= 64'sh0;
		end else begin
			done <= 1'b0;
			if (start && !busy_reg) begin
				quo_reg <= dividend[WIDE_W-1] ? 64'(-dividend) : dividend;
				dvs_reg <= divisor[WIDE_W-1] ? 64'(-divisor) : divisor;
				rem_reg <= 64'h0;
				neg_reg <= dividend[WIDE_W-1] ^ divisor[WIDE_W-1];
				cnt_reg <= 7'h40;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (trial[WIDE_W]) begin
					rem_reg <= rem_sh;
					quo_reg <= {quo_reg[WIDE_W-2:0], 1'b0};
				end else begin
					rem_reg <= trial[WIDE_W-1:0];
					quo_reg <= {quo_reg[WIDE_W-2:0], 1'b1};
				end
				cnt_reg <= cnt_reg - 7'h01;
				if (cnt_reg == 7'h01) begin
					busy_reg <= 1'b0;
					done <= 1'b1;
					// a zero divisor gives all ones, or one for a negative dividend; callers never divide by zero
					if (trial[WIDE_W]) begin
						quotient <= neg_reg ? -$signed({quo_reg[WIDE_W-2:0], 1'b0}) : $signed({quo_reg[WIDE_W-2:0], 1'b0});
					end else begin
						quotient <= neg_reg ? -$signed({quo_reg[WIDE_W-2:0], 1'b1}) : $signed({quo_reg[WIDE_W-2:0], 1'b1});
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/mas_math.sv ====
`timescale 1ns/1ps
`default_nettype none
module mas_math #(
	parameter int TICK_CYCLES = mas_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire mas_pkg::mas_func_t func_sel,
	input wire logic select_switch,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain0,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain1,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain2,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain3,
	input wire logic [mas_pkg::NUM_IN-1:0] ain_connected,
	input wire mas_pkg::mas_units_t ain0_units,
	input wire mas_pkg::mas_units_t ain1_units,
	input wire logic signed [mas_pkg::VAL_W-1:0] scale_low,
	input wire logic signed [mas_pkg::VAL_W-1:0] scale_high,
	input wire logic signed [mas_pkg::VAL_W-1:0] range_low,
	input wire logic signed [mas_pkg::VAL_W-1:0] range_high,
	input wire logic signed [mas_pkg::VAL_W-1:0] offset,
	input wire logic [mas_pkg::FILT_TIME_W-1:0] filter_time,
	input wire mas_pkg::mas_units_t units_sel,
	output logic signed [mas_pkg::VAL_W-1:0] result_value,
	output mas_pkg::mas_units_t result_units,
	output logic result_valid
);
	import mas_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_CALC,
		ST_RAW_WAIT,
		ST_FILT,
		ST_FILT_WAIT,
		ST_OUT
	} mas_state_t;

	function automatic logic signed [WIDE_W-1:0] ext(input logic signed [VAL_W-1:0] v);
		ext = {{(WIDE_W-VAL_W){v[VAL_W-1]}}, v};
	endfunction

	// ------------------------------------------------------------
	// sample tick
	// ------------------------------------------------------------
	logic [31:0] tick_cnt_reg;
	logic tick_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// input snapshot and combinational preparation
	// ------------------------------------------------------------
	// source inputs, connections, function and switch are frozen at the tick so a division sees stable operands
	mas_state_t state_reg;
	mas_func_t func_reg;
	logic sw_reg;
	logic signed [VAL_W-1:0] in_reg [NUM_IN];
	logic [NUM_IN-1:0] conn_reg;
	logic signed [WIDE_W-1:0] gated [NUM_IN];
	logic signed [WIDE_W-1:0] in_sum;
	logic [2:0] in_cnt;
	logic signed [WIDE_W-1:0] dx;
	logic signed [WIDE_W-1:0] dr;
	logic signed [WIDE_W-1:0] ds;
	logic signed [WIDE_W-1:0] prod;

	always_ff @(posedge clk) begin
		if (srst) begin
			func_reg <= FUNC_AVERAGE;
			sw_reg <= 1'b0;
			conn_reg <= 4'h0;
			in_reg[0] <= RESULT_RESET;
			in_reg[1] <= RESULT_RESET;
			in_reg[2] <= RESULT_RESET;
			in_reg[3] <= RESULT_RESET;
		end else if (tick_reg && state_reg == ST_IDLE) begin
			func_reg <= func_sel;
			sw_reg <= select_switch;
			conn_reg <= ain_connected;
			in_reg[0] <= ain0;
			in_reg[1] <= ain1;
			in_reg[2] <= ain2;
			in_reg[3] <= ain3;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_gate
			assign gated[gi] = conn_reg[gi] ? ext(in_reg[gi]) : 64'sh0;
		end
	endgenerate

	always_comb begin
		in_sum = gated[0] + gated[1] + gated[2] + gated[3];
		in_cnt = 3'(conn_reg[0]) + 3'(conn_reg[1]) + 3'(conn_reg[2]) + 3'(conn_reg[3]);
		// full 64-bit products keep any settings within range exact
		dx = ext(in_reg[0]) - ext(scale_low);
		dr = ext(range_high) - ext(range_low);
		ds = ext(scale_high) - ext(scale_low);
		prod = dx * dr;
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	logic div_done;
	logic signed [WIDE_W-1:0] div_q;
	logic [FILT_TIME_W-1:0] tau;

	always_comb begin
		tau = (filter_time > FILT_MAX_TENTHS) ? FILT_MAX_TENTHS : filter_time;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (tick_reg) begin
						state_reg <= ST_CALC;
					end
				end
				ST_CALC: begin
					case (func_reg)
						FUNC_AVERAGE: state_reg <= (in_cnt == 3'h0) ? ST_FILT : ST_RAW_WAIT;
						FUNC_SWITCH_OVER: state_reg <= ST_FILT;
						default: state_reg <= (sw_reg || ds == 64'sh0) ? ST_FILT : ST_RAW_WAIT;
					endcase
				end
				ST_RAW_WAIT: begin
					if (div_done) begin
						state_reg <= ST_FILT;
					end
				end
				ST_FILT: begin
					state_reg <= (tau == FILT_TIME_OFF) ? ST_OUT : ST_FILT_WAIT;
				end
				ST_FILT_WAIT: begin
					if (div_done) begin
						state_reg <= ST_OUT;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// divider requests
	// ------------------------------------------------------------
	logic div_start_reg;
	logic signed [WIDE_W-1:0] div_num_reg;
	logic signed [WIDE_W-1:0] div_den_reg;
	logic signed [VAL_W-1:0] raw_reg;
	logic signed [STATE_W-1:0] filt_reg;
	logic signed [WIDE_W-1:0] filt_diff;

	always_comb begin
		filt_diff = (ext(raw_reg) <<< FRAC_BITS) - {{(WIDE_W-STATE_W){filt_reg[STATE_W-1]}}, filt_reg};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			div_start_reg <= 1'b0;
			div_num_reg <= 64'sh0;
			div_den_reg <= 64'sh0;
		end else begin
			div_start_reg <= 1'b0;
			if (state_reg == ST_CALC) begin
				if (func_reg == FUNC_AVERAGE) begin
					div_num_reg <= in_sum;
					div_den_reg <= $signed({61'h0, in_cnt});
				end else begin
					div_num_reg <= prod;
					div_den_reg <= ds;
				end
				div_start_reg <= (func_reg == FUNC_AVERAGE) ? (in_cnt != 3'h0) :
					(func_reg != FUNC_SWITCH_OVER && !sw_reg && ds != 64'sh0);
			end else if (state_reg == ST_FILT && tau != FILT_TIME_OFF) begin
				// one step of y += (x - y) * dt / tau with dt of one millisecond
				div_num_reg <= filt_diff;
				div_den_reg <= $signed(64'(tau) * 64'(MS_PER_TENTH));
				div_start_reg <= 1'b1;
			end
		end
	end

	mas_div u_div (
		.clk(clk),
		.srst(srst),
		.start(div_start_reg),
		.dividend(div_num_reg),
		.divisor(div_den_reg),
		.done(div_done),
		.quotient(div_q)
	);

	// ------------------------------------------------------------
	// unfiltered result
	// ------------------------------------------------------------
	// results outside the 32-bit word wrap; only the filter time is clamped, never a result
	always_ff @(posedge clk) begin
		if (srst) begin
			raw_reg <= RESULT_RESET;
		end else if (state_reg == ST_CALC) begin
			case (func_reg)
				FUNC_AVERAGE: begin
					raw_reg <= RESULT_RESET;
				end
				FUNC_SWITCH_OVER: begin
					raw_reg <= sw_reg ? in_reg[1] : in_reg[0];
				end
				FUNC_PROCESS_SCALE: begin
					raw_reg <= sw_reg ? in_reg[1] : range_low;
				end
				default: begin
					// degenerate line with equal scale points gives range low plus input 1
					raw_reg <= sw_reg ? in_reg[1] : VAL_W'(ext(range_low) + ext(in_reg[1]));
				end
			endcase
		end else if (state_reg == ST_RAW_WAIT && div_done) begin
			case (func_reg)
				FUNC_AVERAGE: raw_reg <= div_q[VAL_W-1:0];
				FUNC_PROCESS_SCALE: raw_reg <= VAL_W'(ext(range_low) + div_q);
				default: raw_reg <= VAL_W'(ext(range_low) + div_q + ext(in_reg[1]));
			endcase
		end
	end

	// ------------------------------------------------------------
	// smoothing filter
	// ------------------------------------------------------------
	// extra fraction bits keep small steps from stalling short of the input
	always_ff @(posedge clk) begin
		if (srst) begin
			filt_reg <= FILT_STATE_RESET;
		end else if (state_reg == ST_FILT && tau == FILT_TIME_OFF) begin
			filt_reg <= {raw_reg, {FRAC_BITS{1'b0}}};
		end else if (state_reg == ST_FILT_WAIT && div_done) begin
			filt_reg <= filt_reg + div_q[STATE_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// output and units
	// ------------------------------------------------------------
	mas_units_t units_next;

	always_comb begin
		case (func_reg)
			FUNC_AVERAGE: units_next = ain0_units;
			FUNC_SWITCH_OVER: units_next = sw_reg ? ain1_units : ain0_units;
			FUNC_PROCESS_SCALE: begin
				if (units_sel == UNITS_SOURCE) begin
					units_next = sw_reg ? ain0_units : ain1_units;
				end else begin
					// a power tag marks a 0 to 100 percent signal
					units_next = units_sel;
				end
			end
			default: units_next = ain1_units;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			result_value <= RESULT_RESET;
			result_units <= UNITS_NONE;
			result_valid <= 1'b0;
		end else begin
			result_valid <= (state_reg == ST_OUT);
			if (state_reg == ST_OUT) begin
				result_value <= filt_reg[STATE_W-1:FRAC_BITS] + offset;
				result_units <= units_next;
			end
		end
	end

endmodule
`default_nettype wire

// ==== bench/mas_math_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mas_math_chk #(
	parameter int TICK_CYCLES = mas_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire mas_pkg::mas_func_t func_sel,
	input wire logic select_switch,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain0,
	input wire logic signed [mas_pkg::VAL_W-1:0] ain1,
	input wire logic signed [mas_pkg::VAL_W-1:0] offset,
	input wire logic [mas_pkg::FILT_TIME_W-1:0] filter_time,
	input wire mas_pkg::mas_units_t ain0_units,
	input wire mas_pkg::mas_units_t ain1_units,
	input wire mas_pkg::mas_units_t units_sel,
	input wire logic signed [mas_pkg::VAL_W-1:0] result_value,
	input wire mas_pkg::mas_units_t result_units,
	input wire logic result_valid
);
	import mas_pkg::*;
	// ------------------------------------------------------------
	// spacing counter
	// ------------------------------------------------------------
	// one update per tick, so pulses can be neither crowded nor missing
	int unsigned gap_reg;
	always_ff @(posedge clk) begin
		if (srst || result_valid)
			gap_reg <= 0;
		else
			gap_reg <= gap_reg + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	reset_values_a: assert property (disable iff (1'b0) srst |=> result_value == 0 && !result_valid &&
		result_units == UNITS_NONE) else $error("outputs not cleared by reset");
	valid_pulse_a: assert property (result_valid |=> !result_valid) else $error("valid longer than one cycle");
	value_hold_a: assert property (!result_valid |-> $stable(result_value)) else $error("value moved");
	units_hold_a: assert property (!result_valid |-> $stable(result_units)) else $error("units moved");
	tick_spacing_a: assert property (result_valid |-> gap_reg >= TICK_CYCLES / 2) else $error("updates too close");
	tick_deadline_a: assert property (gap_reg <= 2 * TICK_CYCLES) else $error("update missing");
	switch_value_a: assert property (result_valid && func_sel == FUNC_SWITCH_OVER && filter_time == 0 |->
		result_value == (select_switch ? ain1 : ain0) + offset) else $error("switch value wrong");
	switch_units_a: assert property (result_valid && func_sel == FUNC_SWITCH_OVER |->
		result_units == (select_switch ? ain1_units : ain0_units)) else $error("switch units wrong");
	dev_units_a: assert property (result_valid && func_sel == FUNC_DEVIATION_SCALE |->
		result_units == ain1_units) else $error("deviation units wrong");
	proc_units_a: assert property (result_valid && func_sel == FUNC_PROCESS_SCALE |-> result_units ==
		(units_sel != UNITS_SOURCE ? units_sel : select_switch ? ain0_units : ain1_units)) else $error("units tag wrong");
	cover property (result_valid && func_sel == FUNC_AVERAGE);
	cover property (result_valid && func_sel == FUNC_SWITCH_OVER && select_switch);
	cover property (result_valid && func_sel == FUNC_PROCESS_SCALE);
	cover property (result_valid && func_sel == FUNC_DEVIATION_SCALE && filter_time != 0);
endmodule
bind mas_math mas_math_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== bench/mas_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// upstream blocks feeding the analog and digital inputs
// ------------------------------------------------------------
module mas_src (
	input wire logic clk,
	output logic signed [mas_pkg::VAL_W-1:0] ain0,
	output logic signed [mas_pkg::VAL_W-1:0] ain1,
	output logic signed [mas_pkg::VAL_W-1:0] ain2,
	output logic signed [mas_pkg::VAL_W-1:0] ain3,
	output logic [mas_pkg::NUM_IN-1:0] ain_connected,
	output logic select_switch,
	output mas_pkg::mas_units_t ain0_units,
	output mas_pkg::mas_units_t ain1_units
);
	import mas_pkg::*;
	initial begin
		{ain0, ain1, ain2, ain3, ain_connected, select_switch} = '0;
		ain0_units = UNITS_ABS_TEMP;
		ain1_units = UNITS_REL_HUMIDITY;
	end
	// unconnected slots still carry junk, as a real idle source would
	task automatic drive(input logic sw, input logic signed [VAL_W-1:0] a0, a1, a2, a3, input logic [3:0] cn);
		@(posedge clk);
		#1;
		{select_switch, ain0, ain1, ain2, ain3, ain_connected} = {sw, a0, a1, a2, a3, cn};
	endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0d got %0d", nm, ex, got); end end
module testbench;
	import mas_pkg::*;
	typedef struct {
		mas_func_t f;
		logic sw;
		logic signed [31:0] a0, a1, a2, a3;
		logic [3:0] cn;
		logic signed [31:0] sl, sh, rl, rh, off;
		mas_units_t us;
		logic signed [31:0] ev;
		mas_units_t eu;
		logic [9:0] ft;
	} mas_row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	mas_func_t func_sel = FUNC_AVERAGE;
	mas_units_t units_sel = UNITS_SOURCE;
	logic signed [31:0] scale_low = 0, scale_high = 0, range_low = 0, range_high = 0, offset = 0;
	logic [9:0] filter_time = 10'h000;
	logic signed [31:0] ain0, ain1, ain2, ain3, result_value;
	logic [3:0] ain_connected;
	logic select_switch, result_valid;
	mas_units_t ain0_units, ain1_units, result_units;
	int n_fail = 0;
	int cmp_count = 0;
	mas_row_t rows[12] = '{
		'{FUNC_AVERAGE, 0, 1000, 2000, 3000, 4000, 4'hF, 0, 0, 0, 0, 0, UNITS_SOURCE, 2500, UNITS_ABS_TEMP, 0},
		'{FUNC_AVERAGE, 0, 1000, 77777, 3000, -5, 4'h5, 0, 0, 0, 0, 500, UNITS_SOURCE, 2500, UNITS_ABS_TEMP, 0},
		'{FUNC_AVERAGE, 0, -1000, -1000, -1001, 9, 4'h7, 0, 0, 0, 0, -99999000, UNITS_SOURCE, -100000000,
			UNITS_ABS_TEMP, 0},
		'{FUNC_SWITCH_OVER, 0, 5000, 7000, 0, 0, 0, 0, 0, 0, 0, 1000, UNITS_SOURCE, 6000, UNITS_ABS_TEMP, 0},
		'{FUNC_SWITCH_OVER, 1, 5000, 7000, 0, 0, 0, 0, 0, 0, 0, 1000, UNITS_SOURCE, 8000, UNITS_REL_HUMIDITY, 0},
		'{FUNC_PROCESS_SCALE, 0, 5000, 1, 0, 0, 0, 0, 10000, 0, 100000, 0, UNITS_PROCESS, 50000, UNITS_PROCESS, 0},
		'{FUNC_PROCESS_SCALE, 0, 20000, 1, 0, 0, 0, 0, 10000, 0, 100000, 0, UNITS_PROCESS, 200000, UNITS_PROCESS, 0},
		'{FUNC_PROCESS_SCALE, 0, 2500, 1, 0, 0, 0, 10000, 0, 0, 100000, 0, UNITS_NONE, 75000, UNITS_NONE, 0},
		'{FUNC_PROCESS_SCALE, 0, 12345, 1, 0, 0, 0, -99999000, 99999000, -99999000, 99999000, 0, UNITS_POWER, 12345,
			UNITS_POWER, 0},
		'{FUNC_DEVIATION_SCALE, 0, 0, 10000, 0, 0, 0, 0, 1000, 500, 1500, 0, UNITS_SOURCE, 10500, UNITS_REL_HUMIDITY, 0},
		'{FUNC_DEVIATION_SCALE, 0, 1000, 10000, 0, 0, 0, 0, 1000, 500, 1500, 0, UNITS_NONE, 11500, UNITS_REL_HUMIDITY, 0},
		'{FUNC_DEVIATION_SCALE, 1, 1000, 10000, 0, 0, 0, 0, 1000, 500, 1500, 0, UNITS_NONE, 10000, UNITS_REL_HUMIDITY, 0}
	};
	logic [9:0] fts[4] = '{10'h001, 10'h002, 10'h258, 10'h2BC};
	logic signed [31:0] fexp[4] = '{1000, 500, 1, 1};
	mas_row_t r;
	mas_src u_src (.clk(clk), .ain0(ain0), .ain1(ain1), .ain2(ain2), .ain3(ain3), .ain_connected(ain_connected),
		.select_switch(select_switch), .ain0_units(ain0_units), .ain1_units(ain1_units));
	mas_math #(.TICK_CYCLES(300)) u_dut (.clk(clk), .srst(srst), .func_sel(func_sel), .select_switch(select_switch),
		.ain0(ain0), .ain1(ain1), .ain2(ain2), .ain3(ain3), .ain_connected(ain_connected), .ain0_units(ain0_units),
		.ain1_units(ain1_units), .scale_low(scale_low), .scale_high(scale_high), .range_low(range_low),
		.range_high(range_high), .offset(offset), .filter_time(filter_time), .units_sel(units_sel),
		.result_value(result_value), .result_units(result_units), .result_valid(result_valid));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// sampled on the falling edge so the register updates have landed
	task automatic wait_valid;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (result_valid !== 1'b1 && n < 1000);
		if (n >= 1000)
			n_fail++;
	endtask
	// settings change only just after an update, well clear of the next tick
	task automatic run(input mas_row_t x);
		@(posedge clk);
		#1;
		func_sel = x.f;
		units_sel = x.us;
		{scale_low, scale_high, range_low, range_high} = {x.sl, x.sh, x.rl, x.rh};
		{offset, filter_time} = {x.off, x.ft};
		u_src.drive(x.sw, x.a0, x.a1, x.a2, x.a3, x.cn);
		wait_valid();
		`CHK("result_value", x.ev, result_value)
		`CHK("result_units", x.eu, result_units)
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		foreach (rows[i])
			run(rows[i]);
		// no source connected: the mean falls back to zero
		r = rows[0];
		{r.cn, r.ev} = {4'h0, 32'sd0};
		run(r);
		for (int u = 0; u < 7; u++) begin
			r = rows[5];
			r.sw = 1'b1;
			r.a1 = 4321;
			r.ev = 4321;
			r.us = mas_units_t'(u);
			r.eu = (u == 0) ? UNITS_ABS_TEMP : r.us;
			run(r);
		end
		for (int i = 0; i < 4; i++) begin
			r = rows[3];
			{r.off, r.a0, r.ev, r.ft} = '0;
			run(r);
			{r.a0, r.ev, r.ft} = {32'sd100000, fexp[i], fts[i]};
			run(r);
		end
		@(posedge clk);
		#1;
		srst = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("reset value", 0, result_value)
		`CHK("reset units", UNITS_NONE, result_units)
		@(posedge clk);
		#1;
		srst = 1'b0;
		r = rows[3];
		r.ev = 6000;
		run(r);
		final_report();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
